//--- scr_pkg.sv
package scr_pkg;

  // ----------------------------------------------------------------
  // register window
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_CAP = 16'h0000;
  localparam logic [15:0] OFS_CAP_HI = 16'h0004;
  localparam logic [15:0] OFS_VER = 16'h0008;
  localparam logic [15:0] OFS_MSK_SET = 16'h000C;
  localparam logic [15:0] OFS_MSK_CLR = 16'h0010;
  localparam logic [15:0] OFS_CFG = 16'h0014;
  localparam logic [15:0] OFS_RSVD = 16'h0018;
  localparam logic [15:0] OFS_STAT = 16'h001C;
  localparam logic [15:0] OFS_SSR = 16'h0020;
  localparam logic [15:0] OFS_QATTR = 16'h0024;
  localparam logic [15:0] OFS_SQB = 16'h0028;
  localparam logic [15:0] OFS_SQB_HI = 16'h002C;
  localparam logic [15:0] OFS_CQB = 16'h0030;
  localparam logic [15:0] OFS_CQB_HI = 16'h0034;
  localparam logic [15:0] DB_BASE = 16'h1000;
  localparam logic [15:0] DB_WIDTH_BYTES = 16'h0004;
  localparam int DB_MIN_SHIFT = 2;

  // ----------------------------------------------------------------
  // transfer sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] SZ_B1 = 2'h0;
  localparam logic [1:0] SZ_B2 = 2'h1;
  localparam logic [1:0] SZ_B4 = 2'h2;
  localparam logic [1:0] SZ_B8 = 2'h3;
  localparam logic [7:0] BE_B1 = 8'h01;
  localparam logic [7:0] BE_B2 = 8'h03;
  localparam logic [7:0] BE_B4 = 8'h0F;
  localparam logic [7:0] BE_B8 = 8'hFF;
  localparam logic [2:0] AL_B1 = 3'h0;
  localparam logic [2:0] AL_B2 = 3'h1;
  localparam logic [2:0] AL_B4 = 3'h3;
  localparam logic [2:0] AL_B8 = 3'h7;

  // ----------------------------------------------------------------
  // capability field positions
  // ----------------------------------------------------------------
  localparam int CAP_MQES_LSB = 0;
  localparam int CAP_CQR_LSB = 16;
  localparam int CAP_ARB_LSB = 17;
  localparam int CAP_TO_LSB = 24;
  localparam int CAP_DBS_LSB = 32;
  localparam int CAP_SSR_LSB = 36;
  localparam int CAP_CMDSET_LSB = 37;
  localparam int CAP_PGMIN_LSB = 48;
  localparam int CAP_PGMAX_LSB = 52;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_DW = 32'h0000_0000;
  localparam logic [63:0] RST_QW = 64'h0000_0000_0000_0000;

endpackage : scr_pkg

//--- scr_db_mem.sv
`timescale 1ns/1ps
module scr_db_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_be_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  output logic [31:0] rd_data_o
);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0] rd;
  } scr_mem_s;

  scr_mem_s cur_reg;
  scr_mem_s cur_next;

  // ----------------------------------------------------------------
  // byte-masked write, registered read of old contents
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_next = cur_reg;
    cur_next.rd = cur_reg.mem[addr_i];
    if (wr_en_i)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_be_i[b])
        begin
          cur_next.mem[addr_i][8*b +: 8] = wr_data_i[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cur_reg <= '0;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  assign rd_data_o = cur_reg.rd;

endmodule : scr_db_mem

//--- scr_regs.sv
`timescale 1ns/1ps
// Functional notes
// - registers live in one memory window; host maps it ordered, any width
// - locked read-modify-write is not supported; lock carries no state
// - unaligned access is answered with completer abort
// - undefined locations and reserved bits read zero, ignore writes
// - fixed map: capability 00h, version 08h, masks 0Ch/10h, config 14h...
// - doorbells start 1000h; tail at 2y strides, head at 2y+1 strides
// - each doorbell is a 32-bit register regardless of stride
// - stride field 35:32 gives spacing of 2^(2+field) bytes
// - bits 55:52 give largest page size 2^(12+field)
// - bits 51:48 give smallest page size 2^(12+field)
// - bits 44:37 flag command sets; bit 37 primary; one set at least
// - bit 36 reports subsystem reset support
// - bits 31:24 give ready timeout in 500 ms units
// - bits 18:17 flag weighted round robin and vendor arbitration
module scr_regs #(
  parameter int NUM_QP = 4,
  parameter logic [15:0] MQES = 16'h003F,
  parameter logic CQR = 1'b1,
  parameter logic [1:0] ARB_OPTS = 2'h0,
  parameter logic [7:0] TO = 8'h14,
  parameter logic [3:0] DB_SPACING = 4'h0,
  parameter logic SSR_AVAIL = 1'b1,
  parameter logic [7:0] CMD_SETS = 8'h01,
  parameter logic [3:0] PG_MIN = 4'h0,
  parameter logic [3:0] PG_MAX = 4'h0,
  parameter logic [31:0] VERSION = 32'h0001_0000
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [scr_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [1:0] req_size_i,
  input wire logic [63:0] req_wdata_i,
  input wire logic [31:0] ctrl_status_i,
  output logic cpl_valid_o,
  output logic cpl_abort_o,
  output logic [63:0] cpl_rdata_o,
  output logic [31:0] irq_mask_o,
  output logic [31:0] ctrl_config_o,
  output logic [31:0] admin_queue_attr_o,
  output logic [63:0] admin_sq_base_o,
  output logic [63:0] admin_cq_base_o,
  output logic subsys_reset_o,
  output logic db_write_o,
  output logic [$clog2(2*NUM_QP)-1:0] db_index_o,
  output logic [3:0] db_be_o,
  output logic [31:0] db_value_o
);

  localparam int DB_DEPTH = 2 * NUM_QP;
  localparam int DB_IW = $clog2(DB_DEPTH);

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] cfg;
    logic [31:0] ssr;
    logic [31:0] qattr;
    logic [63:0] sqb;
    logic [63:0] cqb;
    logic p_valid;
    logic p_abort;
    logic p_db;
    logic p_lane;
    logic [63:0] p_data;
    logic cpl_valid;
    logic cpl_abort;
    logic [63:0] cpl_data;
    logic ssr_pulse;
    logic db_wr;
    logic [DB_IW-1:0] db_idx;
    logic [3:0] db_be;
    logic [31:0] db_val;
  } scr_state_s;

  scr_state_s cur_reg;
  scr_state_s cur_next;

  function automatic logic [31:0] scr_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : scr_merge

  // ----------------------------------------------------------------
  // capability value
  // ----------------------------------------------------------------
  logic [63:0] cap_val;

  always_comb
  begin
    cap_val = scr_pkg::RST_QW;
    cap_val[scr_pkg::CAP_MQES_LSB +: 16] = MQES;
    cap_val[scr_pkg::CAP_CQR_LSB] = CQR;
    cap_val[scr_pkg::CAP_ARB_LSB +: 2] = ARB_OPTS;
    cap_val[scr_pkg::CAP_TO_LSB +: 8] = TO;
    cap_val[scr_pkg::CAP_DBS_LSB +: 4] = DB_SPACING;
    cap_val[scr_pkg::CAP_SSR_LSB] = SSR_AVAIL;
    cap_val[scr_pkg::CAP_CMDSET_LSB +: 8] = CMD_SETS;
    cap_val[scr_pkg::CAP_PGMIN_LSB +: 4] = PG_MIN;
    cap_val[scr_pkg::CAP_PGMAX_LSB +: 4] = PG_MAX;
  end

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic [7:0] be8;
  logic [2:0] al_mask;
  logic unaligned;
  logic [15:0] rel;
  logic [15:0] slot_off;
  logic [15:0] db_idx_full;
  logic db_hit;
  logic [3:0] db_be;
  logic [31:0] db_wd;
  logic [31:0] db_rd;

  always_comb
  begin
    case (req_size_i)
      scr_pkg::SZ_B1:
      begin
        be8 = scr_pkg::BE_B1;
        al_mask = scr_pkg::AL_B1;
      end
      scr_pkg::SZ_B2:
      begin
        be8 = scr_pkg::BE_B2;
        al_mask = scr_pkg::AL_B2;
      end
      scr_pkg::SZ_B4:
      begin
        be8 = scr_pkg::BE_B4;
        al_mask = scr_pkg::AL_B4;
      end
      default:
      begin
        be8 = scr_pkg::BE_B8;
        al_mask = scr_pkg::AL_B8;
      end
    endcase
    be8 = be8 << req_addr_i[2:0];
    unaligned = (req_addr_i[2:0] & al_mask) != 3'h0;
    rel = req_addr_i - scr_pkg::DB_BASE;
    db_idx_full = rel >> (scr_pkg::DB_MIN_SHIFT + int'(DB_SPACING));
    slot_off = rel & ((16'h0001 << (scr_pkg::DB_MIN_SHIFT + int'(DB_SPACING))) - 16'h0001);
    db_hit = (req_addr_i >= scr_pkg::DB_BASE)
      && (slot_off < scr_pkg::DB_WIDTH_BYTES)
      && (db_idx_full < 16'(DB_DEPTH));
    db_be = req_addr_i[2] ? be8[7:4] : be8[3:0];
    db_wd = req_addr_i[2] ? req_wdata_i[63:32] : req_wdata_i[31:0];
  end

  // ----------------------------------------------------------------
  // register file and answer pipeline
  // ----------------------------------------------------------------
  logic [15:0] da;
  logic [3:0] bel;
  logic [31:0] wd;
  logic [31:0] rd;
  logic do_wr;

  always_comb
  begin
    da = 16'h0000;
    bel = 4'h0;
    wd = scr_pkg::RST_DW;
    rd = scr_pkg::RST_DW;
    do_wr = 1'b0;
    cur_next = cur_reg;
    // locked requests are not distinguished: no lock state is kept
    cur_next.p_valid = req_valid_i;
    cur_next.p_abort = req_valid_i && unaligned;
    cur_next.p_db = 1'b0;
    cur_next.p_lane = req_addr_i[2];
    cur_next.p_data = scr_pkg::RST_QW;
    cur_next.cpl_valid = cur_reg.p_valid;
    cur_next.cpl_abort = cur_reg.p_abort;
    if (cur_reg.p_db)
    begin
      cur_next.cpl_data = cur_reg.p_lane ? {db_rd, scr_pkg::RST_DW} : {scr_pkg::RST_DW, db_rd};
    end
    else
    begin
      cur_next.cpl_data = cur_reg.p_data;
    end
    cur_next.ssr_pulse = 1'b0;
    cur_next.db_wr = 1'b0;
    if (req_valid_i && !unaligned && (req_addr_i < scr_pkg::DB_BASE))
    begin
      for (int l = 0; l < 2; l++)
      begin
        da = {req_addr_i[15:3], l[0], 2'b00};
        bel = be8[4*l +: 4];
        wd = req_wdata_i[32*l +: 32];
        do_wr = req_write_i && (bel != 4'h0);
        rd = scr_pkg::RST_DW;
        case (da)
          scr_pkg::OFS_CAP: rd = cap_val[31:0];
          scr_pkg::OFS_CAP_HI: rd = cap_val[63:32];
          scr_pkg::OFS_VER: rd = VERSION;
          scr_pkg::OFS_MSK_SET:
          begin
            rd = cur_reg.mask;
            if (do_wr)
            begin
              cur_next.mask = cur_reg.mask | (wd & scr_merge(scr_pkg::RST_DW, ~scr_pkg::RST_DW, bel));
            end
          end
          scr_pkg::OFS_MSK_CLR:
          begin
            rd = cur_reg.mask;
            if (do_wr)
            begin
              cur_next.mask = cur_reg.mask & ~(wd & scr_merge(scr_pkg::RST_DW, ~scr_pkg::RST_DW, bel));
            end
          end
          scr_pkg::OFS_CFG:
          begin
            rd = cur_reg.cfg;
            if (do_wr)
            begin
              cur_next.cfg = scr_merge(cur_reg.cfg, wd, bel);
            end
          end
          scr_pkg::OFS_STAT: rd = ctrl_status_i;
          scr_pkg::OFS_SSR:
          begin
            if (SSR_AVAIL)
            begin
              rd = cur_reg.ssr;
              if (do_wr)
              begin
                cur_next.ssr = scr_merge(cur_reg.ssr, wd, bel);
                cur_next.ssr_pulse = 1'b1;
              end
            end
          end
          scr_pkg::OFS_QATTR:
          begin
            rd = cur_reg.qattr;
            if (do_wr)
            begin
              cur_next.qattr = scr_merge(cur_reg.qattr, wd, bel);
            end
          end
          scr_pkg::OFS_SQB:
          begin
            rd = cur_reg.sqb[31:0];
            if (do_wr)
            begin
              cur_next.sqb[31:0] = scr_merge(cur_reg.sqb[31:0], wd, bel);
            end
          end
          scr_pkg::OFS_SQB_HI:
          begin
            rd = cur_reg.sqb[63:32];
            if (do_wr)
            begin
              cur_next.sqb[63:32] = scr_merge(cur_reg.sqb[63:32], wd, bel);
            end
          end
          scr_pkg::OFS_CQB:
          begin
            rd = cur_reg.cqb[31:0];
            if (do_wr)
            begin
              cur_next.cqb[31:0] = scr_merge(cur_reg.cqb[31:0], wd, bel);
            end
          end
          scr_pkg::OFS_CQB_HI:
          begin
            rd = cur_reg.cqb[63:32];
            if (do_wr)
            begin
              cur_next.cqb[63:32] = scr_merge(cur_reg.cqb[63:32], wd, bel);
            end
          end
          default: rd = scr_pkg::RST_DW;
        endcase
        if (!req_write_i)
        begin
          cur_next.p_data[32*l +: 32] = rd & scr_merge(scr_pkg::RST_DW, ~scr_pkg::RST_DW, bel);
        end
      end
    end
    if (req_valid_i && !unaligned && db_hit && (db_be != 4'h0))
    begin
      cur_next.p_db = !req_write_i;
      if (req_write_i)
      begin
        cur_next.db_wr = 1'b1;
        cur_next.db_idx = db_idx_full[DB_IW-1:0];
        cur_next.db_be = db_be;
        cur_next.db_val = db_wd;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cur_reg <= '0;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // doorbell storage
  // ----------------------------------------------------------------
  scr_db_mem #(
    .DEPTH(DB_DEPTH),
    .AW(DB_IW)
  ) u_db_mem (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .wr_en_i(cur_next.db_wr),
    .wr_be_i(db_be),
    .addr_i(db_idx_full[DB_IW-1:0]),
    .wr_data_i(db_wd),
    .rd_data_o(db_rd)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpl_valid_o = cur_reg.cpl_valid;
  assign cpl_abort_o = cur_reg.cpl_abort;
  assign cpl_rdata_o = cur_reg.cpl_data;
  assign irq_mask_o = cur_reg.mask;
  assign ctrl_config_o = cur_reg.cfg;
  assign admin_queue_attr_o = cur_reg.qattr;
  assign admin_sq_base_o = cur_reg.sqb;
  assign admin_cq_base_o = cur_reg.cqb;
  assign subsys_reset_o = cur_reg.ssr_pulse;
  assign db_write_o = cur_reg.db_wr;
  assign db_index_o = cur_reg.db_idx;
  assign db_be_o = cur_reg.db_be;
  assign db_value_o = cur_reg.db_val;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_answer_latency: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i |-> ##2 cpl_valid_o)
    else $error("answer not two cycles after request");

  chk_unaligned_abort: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && unaligned |-> ##2 (cpl_valid_o && cpl_abort_o))
    else $error("unaligned access not aborted");

  chk_aligned_done: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && !unaligned |-> ##2 !cpl_abort_o)
    else $error("aligned access aborted");

  chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && !req_write_i && req_addr_i == scr_pkg::OFS_RSVD
    && req_size_i == scr_pkg::SZ_B4 |-> ##2 cpl_rdata_o == scr_pkg::RST_QW)
    else $error("reserved location read nonzero");

  chk_cap_read: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && !req_write_i && req_addr_i == scr_pkg::OFS_CAP
    && req_size_i == scr_pkg::SZ_B8 |-> ##2 cpl_rdata_o == cap_val)
    else $error("capability read wrong");

  chk_cap_fields: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cap_val[scr_pkg::CAP_CMDSET_LSB +: 8] != 8'h00)
    else $error("no command set flagged");

  chk_page_limits: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    cap_val[scr_pkg::CAP_PGMIN_LSB +: 4] <= cap_val[scr_pkg::CAP_PGMAX_LSB +: 4])
    else $error("page size limits inverted");

  chk_mask_set: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && req_write_i && req_addr_i == scr_pkg::OFS_MSK_SET
    && req_size_i == scr_pkg::SZ_B4
    |=> (irq_mask_o & $past(req_wdata_i[63:32])) == $past(req_wdata_i[63:32]))
    else $error("mask set did not set bits");

  chk_mask_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && req_write_i && req_addr_i == scr_pkg::OFS_MSK_CLR
    && req_size_i == scr_pkg::SZ_B4
    |=> (irq_mask_o & $past(req_wdata_i[31:0])) == scr_pkg::RST_DW)
    else $error("mask clear did not clear bits");

  chk_db_stride: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && req_write_i && req_size_i == scr_pkg::SZ_B4 && req_addr_i ==
    16'(scr_pkg::DB_BASE + (scr_pkg::DB_WIDTH_BYTES << DB_SPACING))
    |=> db_write_o && db_index_o == DB_IW'(1))
    else $error("head doorbell index wrong");

  chk_subsystem_reset_trigger_pulse: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    req_valid_i && req_write_i && req_addr_i == scr_pkg::OFS_SSR && req_size_i == scr_pkg::SZ_B4
    |=> subsys_reset_o == SSR_AVAIL)
    else $error("subsystem reset pulse wrong");

endmodule : scr_regs

//--- scr_host_model.sv
`timescale 1ns/1ps
// ----
// host bus master
// ----
module scr_host_model (
  input wire logic sys_clk_i,
  input wire logic cpl_valid_i,
  input wire logic cpl_abort_i,
  input wire logic [63:0] cpl_rdata_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [15:0] req_addr_o,
  output logic [1:0] req_size_o,
  output logic [63:0] req_wdata_o
);
  initial
  begin
    req_valid_o = 1'h0;
    req_write_o = 1'h0;
    req_addr_o = 16'h0000;
    req_size_o = 2'h0;
    req_wdata_o = 64'h0;
  end

  // one plain request, never locked; answer awaited with a bound
  task automatic access(input logic wr, input logic [15:0] addr, input logic [1:0] size,
    input logic [63:0] wdata, output logic [63:0] rdata, output logic abort,
    output logic done);
    @(posedge sys_clk_i);
    req_valid_o <= 1'h1;
    req_write_o <= wr;
    req_addr_o <= addr;
    req_size_o <= size;
    req_wdata_o <= wdata;
    @(posedge sys_clk_i);
    req_valid_o <= 1'h0;
    req_write_o <= ~wr;
    req_wdata_o <= ~wdata;
    done = 1'h0;
    rdata = 64'h0;
    abort = 1'h0;
    for (int n = 0; n < 8 && !done; n++)
    begin
      @(posedge sys_clk_i);
      if (cpl_valid_i === 1'h1)
      begin
        done = 1'h1;
        rdata = cpl_rdata_i;
        abort = cpl_abort_i;
      end
    end
  endtask : access

  // wide register in narrow pieces, low bytes first
  task automatic split_write(input logic [15:0] base, input logic [1:0] size,
    input logic [63:0] value, output logic ok);
    logic [63:0] rd;
    logic ab;
    logic dn;
    ok = 1'h1;
    for (int k = 0; k < 8; k += (1 << size))
    begin
      access(1'h1, base + 16'(k), size, value, rd, ab, dn);
      ok = ok & dn & ~ab;
    end
  endtask : split_write
endmodule : scr_host_model

//--- storage_ctrl_register_map_tb.sv
`timescale 1ns/1ps
module storage_ctrl_register_map_tb;
  // ----
  // bench setup
  // ----
  localparam logic [1:0] P_ARB = 2'h3;
  localparam logic [7:0] P_WAIT = 8'h2A;
  localparam logic [3:0] P_STRD = 4'h1;
  localparam logic [3:0] P_MIN = 4'h1;
  localparam logic [3:0] P_MAX = 4'h3;
  localparam int STRIDE = 4 << P_STRD;
  localparam logic [63:0] EXP_CAPS = {8'h00, P_MAX, P_MIN, 3'h0, 8'h01, 1'h1, P_STRD,
    P_WAIT, 5'h00, P_ARB, 1'h1, 16'h003F};
  localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
  logic sys_clk, nrst, req_valid, req_write, cpl_valid, cpl_abort, ssr, db_write;
  logic [15:0] req_addr;
  logic [1:0] req_size;
  logic [63:0] req_wdata, cpl_rdata, adm_sq, adm_cq, rd;
  logic [31:0] ctrl_status, irq_mask, ctrl_cfg, aq_attr, db_value;
  logic [2:0] db_index;
  logic [3:0] db_be;
  logic [38:0] db_q;
  int failures = 0;
  int samples_checked = 0;
  int db_seen = 0;
  int ssr_seen = 0;

  scr_regs #(.ARB_OPTS(P_ARB), .TO(P_WAIT), .DB_SPACING(P_STRD), .PG_MIN(P_MIN),
    .PG_MAX(P_MAX)) i_dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_size_i(req_size), .req_wdata_i(req_wdata),
    .ctrl_status_i(ctrl_status), .cpl_valid_o(cpl_valid), .cpl_abort_o(cpl_abort),
    .cpl_rdata_o(cpl_rdata), .irq_mask_o(irq_mask), .ctrl_config_o(ctrl_cfg),
    .admin_queue_attr_o(aq_attr), .admin_sq_base_o(adm_sq), .admin_cq_base_o(adm_cq),
    .subsys_reset_o(ssr), .db_write_o(db_write), .db_index_o(db_index), .db_be_o(db_be),
    .db_value_o(db_value));

  scr_host_model i_host (
    .sys_clk_i(sys_clk), .cpl_valid_i(cpl_valid), .cpl_abort_i(cpl_abort),
    .cpl_rdata_i(cpl_rdata), .req_valid_o(req_valid), .req_write_o(req_write),
    .req_addr_o(req_addr), .req_size_o(req_size), .req_wdata_o(req_wdata));

  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (db_write === 1'h1)
    begin
      db_seen <= db_seen + 1;
      db_q <= {db_index, db_be, db_value};
    end
    if (ssr === 1'h1)
      ssr_seen <= ssr_seen + 1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic wr, input logic [15:0] a, input logic [1:0] s,
    input logic [63:0] wd, input logic ab_exp);
    logic ab;
    logic dn;
    i_host.access(wr, a, s, wd, rd, ab, dn);
    check(64'(dn), 64'h1);
    check(64'(ab), 64'(ab_exp));
  endtask : xfer

  task automatic do_reset;
    nrst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
  endtask : do_reset

  // ----
  // scenarios
  // ----
  task automatic t_caps;
    xfer(1'h0, 16'h0000, scr_pkg::SZ_B8, 64'h0, 1'h0);
    check(rd, EXP_CAPS);
    check(64'(rd[35:32]), 64'(P_STRD));
    check(64'(rd[55:52]), 64'(P_MAX));
    check(64'(rd[51:48]), 64'(P_MIN));
    check(64'(rd[44:37]), 64'h01);
    check(64'(rd[36]), 64'h1);
    check(64'(rd[31:24]), 64'(P_WAIT));
    check(64'(rd[18:17]), 64'(P_ARB));
    xfer(1'h1, 16'h0000, scr_pkg::SZ_B8, ONES, 1'h0);
    xfer(1'h0, 16'h0004, scr_pkg::SZ_B4, 64'h0, 1'h0);
    check(rd, {EXP_CAPS[63:32], 32'h0});
  endtask : t_caps

  task automatic t_mask;
    xfer(1'h0, 16'h0008, scr_pkg::SZ_B4, 64'h0, 1'h0);
    check(rd, 64'h0000_0000_0001_0000);
    xfer(1'h1, 16'h000C, scr_pkg::SZ_B4, 64'hF0F0_00FF_0000_0000, 1'h0);
    check(64'(irq_mask), 64'hF0F0_00FF);
    xfer(1'h1, 16'h0010, scr_pkg::SZ_B4, 64'h0000_0000_F000_00F0, 1'h0);
    check(64'(irq_mask), 64'h00F0_000F);
    xfer(1'h0, 16'h0008, scr_pkg::SZ_B8, 64'h0, 1'h0);
    check(rd, 64'h00F0_000F_0001_0000);
  endtask : t_mask

  task automatic t_queues;
    logic ok;
    xfer(1'h1, 16'h0014, scr_pkg::SZ_B4, 64'h0046_0001_0000_0000, 1'h0);
    check(64'(ctrl_cfg), 64'h0046_0001);
    xfer(1'h1, 16'h0024, scr_pkg::SZ_B4, 64'h001F_001F_0000_0000, 1'h0);
    check(64'(aq_attr), 64'h001F_001F);
    i_host.split_write(16'h0028, scr_pkg::SZ_B4, 64'h1234_5678_9ABC_D000, ok);
    check(adm_sq, 64'h1234_5678_9ABC_D000);
    i_host.split_write(16'h0030, scr_pkg::SZ_B2, 64'hFEDC_BA98_7654_3000, ok);
    check(64'(ok), 64'h1);
    check(adm_cq, 64'hFEDC_BA98_7654_3000);
    xfer(1'h0, 16'h0030, scr_pkg::SZ_B8, 64'h0, 1'h0);
    check(rd, 64'hFEDC_BA98_7654_3000);
  endtask : t_queues

  task automatic t_holes;
    logic [15:0] holes [5] = '{16'h0018, 16'h0038, 16'h0F00, 16'h1004, 16'h1040};
    int n;
    n = db_seen;
    foreach (holes[i])
    begin
      xfer(1'h1, holes[i], scr_pkg::SZ_B4, ONES, 1'h0);
      xfer(1'h0, holes[i], scr_pkg::SZ_B4, 64'h0, 1'h0);
      check(rd, 64'h0);
    end
    check(64'(ctrl_cfg), 64'h0046_0001);
    check(64'(db_seen - n), 64'h0);
  endtask : t_holes

  task automatic t_unaligned;
    logic [15:0] ad [5] = '{16'h0016, 16'h0001, 16'h0004, 16'h1002, 16'h0009};
    logic [1:0] sz [5] = '{scr_pkg::SZ_B4, scr_pkg::SZ_B2, scr_pkg::SZ_B8,
      scr_pkg::SZ_B4, scr_pkg::SZ_B4};
    int n;
    n = db_seen;
    foreach (ad[i])
    begin
      xfer(1'h1, ad[i], sz[i], ONES, 1'h1);
      xfer(1'h0, ad[i], sz[i], 64'h0, 1'h1);
      check(rd, 64'h0);
    end
    check(64'(ctrl_cfg), 64'h0046_0001);
    check(64'(db_seen - n), 64'h0);
  endtask : t_unaligned

  task automatic t_doorbells;
    int n;
    n = db_seen;
    for (int y = 0; y < 4; y++)
    begin
      xfer(1'h1, 16'h1000 + 16'(2 * y * STRIDE), scr_pkg::SZ_B4, 64'(32'h0100 + y), 1'h0);
      check(64'(db_q), {25'h0, 3'(2 * y), 4'hF, 32'h0100 + 32'(y)});
      xfer(1'h1, 16'h1000 + 16'((2 * y + 1) * STRIDE), scr_pkg::SZ_B4, 64'(32'h0200 + y), 1'h0);
      check(64'(db_q), {25'h0, 3'(2 * y + 1), 4'hF, 32'h0200 + 32'(y)});
    end
    check(64'(db_seen - n), 64'h8);
    xfer(1'h0, 16'h1000 + 16'(3 * STRIDE), scr_pkg::SZ_B4, 64'h0, 1'h0);
    check(rd, 64'h0000_0201);
    xfer(1'h1, 16'h1000 + 16'(2 * STRIDE), scr_pkg::SZ_B8, 64'hAAAA_BBBB_CCCC_DDDD, 1'h0);
    xfer(1'h0, 16'h1000 + 16'(2 * STRIDE), scr_pkg::SZ_B8, 64'h0, 1'h0);
    check(rd, 64'h0000_0000_CCCC_DDDD);
  endtask : t_doorbells

  task automatic t_status;
    int n;
    ctrl_status <= 32'h0000_0009;
    xfer(1'h0, 16'h001C, scr_pkg::SZ_B4, 64'h0, 1'h0);
    check(rd, 64'h0000_0009_0000_0000);
    n = ssr_seen;
    xfer(1'h1, 16'h0020, scr_pkg::SZ_B4, 64'h0000_0000_0000_0001, 1'h0);
    check(64'(ssr_seen - n), 64'h1);
    do_reset;
    xfer(1'h0, 16'h0000, scr_pkg::SZ_B8, 64'h0, 1'h0);
    check(rd, EXP_CAPS);
  endtask : t_status

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial
  begin
    nrst = 1'h0;
    ctrl_status = 32'h0;
    do_reset;
    t_caps;
    t_mask;
    t_queues;
    t_holes;
    t_unaligned;
    t_doorbells;
    t_status;
    wrap_up;
  end

  initial
  begin
    #(4 * 20000);
    failures++;
    wrap_up;
  end
endmodule : storage_ctrl_register_map_tb
